// >>> rtl/psu_supervisor_pkg.sv
// constants and types shared by the rectifier supervisor
package psu_supervisor_pkg;

	// clock and the millisecond tick that all timers count
	localparam int CLK_HZ      = 200_000_000;
	localparam int MS_PER_S    = 1000;
	localparam int MS_TICK_CYC = CLK_HZ / MS_PER_S;

	typedef logic [16:0] ms_t;

	// fast restart: outage classes and restart deadlines
	localparam ms_t FAST_ANY_LOAD_MS = 17'd300;
	localparam ms_t FAST_MID_MS      = 17'd800;
	localparam ms_t FAST_LONG_MS     = 17'd1600;
	localparam ms_t FAST_SHORT_DL_MS = 17'd150;
	localparam ms_t FAST_LONG_DL_MS  = 17'd450;
	localparam int  START_DELAY_S    = 10;
	localparam ms_t START_DELAY_MS   = ms_t'(START_DELAY_S * MS_PER_S);

	// start-up constant-current grace, retries, overvoltage window
	localparam int  CC_GRACE_S    = 20;
	localparam ms_t CC_GRACE_MS   = ms_t'(CC_GRACE_S * MS_PER_S);
	localparam int  RETRY_S       = 1;
	localparam ms_t RETRY_MS      = ms_t'(RETRY_S * MS_PER_S);
	localparam int  OV_WINDOW_MIN = 1;
	localparam ms_t OV_WINDOW_MS  = ms_t'(OV_WINDOW_MIN * 60 * MS_PER_S);
	localparam logic [1:0] OV_RETRIES = 2'd3;
	localparam ms_t BLINK_MS      = 17'd250;

	// setpoint pin, 12-bit code over 3.3 v full scale
	localparam logic [11:0] VPROG_LO_CODE = 12'h07c;
	localparam logic [11:0] VPROG_HI_CODE = 12'he8c;
	localparam logic [15:0] VOUT_MIN_MV   = 16'h9c40;
	localparam logic [15:0] VOUT_MAX_MV   = 16'hd6d8;

	// bus addressing
	localparam logic [2:0] ADDR_BASE = 3'h4;
	localparam logic [7:0] ARA_BYTE  = 8'h19;
	localparam logic [7:0] BCAST_WR  = 8'h00;
	localparam logic [7:0] BCAST_RD  = 8'h01;

	typedef enum logic [2:0] {
		st_off,
		st_run,
		st_retry,
		st_hiccup,
		st_latched
	} sup_state_e;

endpackage : psu_supervisor_pkg

// >>> rtl/psu_supervisor.sv
// rectifier supervisor: restart timing, setpoint control, faults, addressing
// Functional notes
// RULE_01 - short outage: regulation within 150 ms
// RULE_02 - mid outage, light load: 150 ms
// RULE_03 - long outage, light load: 450 ms
// RULE_04 - pin level sets setpoint while in control
// RULE_05 - low or open pin gives 40 v
// RULE_06 - pin above 3.0 v gives 55 v
// RULE_07 - serial voltage command takes control until repower
// RULE_08 - start-up overload held constant-current twenty seconds
// RULE_09 - led blinks in limit above 40 v
// RULE_10 - limit below 40 v with restart: hiccup
// RULE_11 - overcurrent, overtemperature default to auto restart
// RULE_12 - overvoltage: three delayed retries, then latch
// RULE_13 - window expiry clears overvoltage count
// RULE_14 - latch-off option for overtemperature, overcurrent
// RULE_15 - listed mechanisms clear a latch-off
// RULE_16 - host keeps unit off two seconds
// RULE_17 - successful restart clears alarms, sets flag
// RULE_18 - host keeps units off for system restart
// RULE_19 - protocol pin selects bus or rs485
// RULE_20 - position pins give four address bits
// RULE_21 - answer at base address plus position
// RULE_22 - answer alert response address, read only
// RULE_23 - broadcast read flagged as invalid command
// RULE_24 - alert response returns own address
// RULE_25 - release alert only on own address
`timescale 1ns/100ps
module psu_supervisor
	import psu_supervisor_pkg::*;
#(
	parameter int TICK_CYC = MS_TICK_CYC
)
(
	input  logic        mclk,
	input  logic        arst_n,
	input  logic        scl_clk,
	input  logic        sda_i,
	output logic        sda_o,
	output logic        sda_oe,
	output logic        alert_o,
	output logic        alert_oe,
	input  logic        ac_ok,
	input  logic        on_pin,
	input  logic        protocol_pin_open,
	input  logic [3:0]  unit_position_pin,
	input  logic [3:0]  rack_position_pin,
	input  logic [11:0] vprog_code,
	input  logic        vout_cmd_valid,
	input  logic [15:0] vout_cmd_mv,
	input  logic        op_on,
	input  logic        restart_cfg_oc,
	input  logic        restart_cfg_ot,
	input  logic        overload,
	input  logic        ov_fault,
	input  logic        ot_fault,
	input  logic        in_limit,
	input  logic        vout_above_40,
	input  logic        vout_in_reg,
	input  logic        light_load,
	input  logic        alert_req,
	input  logic        invalid_clr,
	output logic [15:0] setpoint_mv,
	output logic        serial_ctrl,
	output logic        out_enable,
	output logic        output_led,
	output logic        cc_hold,
	output logic        alarm_ov,
	output logic        alarm_oc,
	output logic        alarm_ot,
	output logic        restart_ok,
	output logic        latched,
	output logic        fast_fail,
	output logic        rs485_mode,
	output logic [3:0]  position_address_bits,
	output logic        invalid_cmd
);

	// position table: four blocks of unit by rack, unused cells give zero
	function automatic logic [3:0] pos_map(input logic [3:0] u,
		input logic [3:0] r);
		logic [7:0] v;
		v = 8'h00;
		if (u >= 4'd1 && u <= 4'd4 && r >= 4'd1 && r <= 4'd4)
			v = 8'((r - 4'd1) * 4'd4 + (u - 4'd1));
		else if (u >= 4'd1 && u <= 4'd5 && r >= 4'd6 && r <= 4'd8)
			v = 8'((r - 4'd6) * 4'd5 + (u - 4'd1));
		else if ((u == 4'd6 || u == 4'd7) && r >= 4'd1 && r <= 4'd8)
			v = 8'((r - 4'd1) * 4'd2 + (u - 4'd6));
		else if (u >= 4'd8 && u <= 4'd10 && r >= 4'd4 && r <= 4'd8)
			v = 8'((r - 4'd4) * 4'd3 + (u - 4'd8));
		return v[3:0];
	endfunction : pos_map

	// pin synchronisers: ac, on, protocol, scl, sda
	logic [4:0] pin_q1;
	logic [4:0] pin_q2;
	logic [4:0] pin_q3;
	logic       ac_s;
	logic       on_s;
	always_ff @(posedge mclk or negedge arst_n)
		if (!arst_n)
		begin
			pin_q1 <= '0;
			pin_q2 <= '0;
			pin_q3 <= '0;
		end
		else
		begin
			pin_q1 <= {sda_i, scl_clk, protocol_pin_open, on_pin, ac_ok};
			pin_q2 <= pin_q1;
			pin_q3 <= pin_q2;
		end
	assign ac_s = pin_q2[0];
	assign on_s = pin_q2[1];

	// millisecond tick shared by every timer
	logic [17:0] tick_cnt;
	logic        tick;
	always_ff @(posedge mclk or negedge arst_n)
		if (!arst_n)
		begin
			tick_cnt <= '0;
			tick     <= 1'b0;
		end
		else
		begin
			tick     <= (tick_cnt == 18'(TICK_CYC - 1));
			tick_cnt <= (tick_cnt == 18'(TICK_CYC - 1)) ? '0 : tick_cnt + 18'd1;
		end

	// outage timing; a fast class skips the normal start delay
	ms_t  outage_ms;
	ms_t  wait_ms;
	ms_t  fr_ms;
	ms_t  dl_ms;
	logic fast;
	logic fr_arm;
	logic ac_ready;
	assign ac_ready = ac_s && (fast || wait_ms >= START_DELAY_MS);
	always_ff @(posedge mclk or negedge arst_n)
		if (!arst_n)
		begin
			outage_ms <= '0;
			wait_ms   <= '0;
			fr_ms     <= '0;
			dl_ms     <= FAST_SHORT_DL_MS;
			fast      <= 1'b0;
			fr_arm    <= 1'b0;
			fast_fail <= 1'b0;
		end
		else if (!ac_s)
		begin
			fr_arm <= 1'b0;
			if (pin_q3[0])
				outage_ms <= '0;
			else if (tick && outage_ms != FAST_LONG_MS)
				outage_ms <= outage_ms + 17'd1;
		end
		else if (!pin_q3[0])
		begin
			fast      <= outage_ms < FAST_ANY_LOAD_MS // see RULE_01
				|| (outage_ms < FAST_LONG_MS && light_load); // see RULE_02
			dl_ms     <= (outage_ms < FAST_MID_MS) ? FAST_SHORT_DL_MS
				: FAST_LONG_DL_MS; // see RULE_03
			fr_arm    <= outage_ms < FAST_ANY_LOAD_MS
				|| (outage_ms < FAST_LONG_MS && light_load);
			fr_ms     <= '0;
			wait_ms   <= '0;
			fast_fail <= 1'b0;
		end
		else
		begin
			if (tick && wait_ms != START_DELAY_MS)
				wait_ms <= wait_ms + 17'd1;
			// deadline watch only flags a miss; recovery is analog
			if (fr_arm && vout_in_reg)
				fr_arm <= 1'b0;
			else if (fr_arm && fr_ms == dl_ms)
			begin
				fr_arm    <= 1'b0;
				fast_fail <= 1'b1;
			end
			else if (fr_arm && tick)
				fr_ms <= fr_ms + 17'd1;
		end

	// setpoint source: pin until the first serial command
	always_ff @(posedge mclk or negedge arst_n)
		if (!arst_n)
		begin
			serial_ctrl <= 1'b0;
			setpoint_mv <= VOUT_MIN_MV;
		end
		else if (vout_cmd_valid)
		begin
			serial_ctrl <= 1'b1; // see RULE_07
			setpoint_mv <= vout_cmd_mv;
		end
		else if (!serial_ctrl)
		begin
			if (vprog_code < VPROG_LO_CODE)
				setpoint_mv <= VOUT_MIN_MV; // see RULE_05
			else if (vprog_code > VPROG_HI_CODE)
				setpoint_mv <= VOUT_MAX_MV; // see RULE_06
			else
				setpoint_mv <= VOUT_MIN_MV + 16'((28'(vprog_code - VPROG_LO_CODE)
					* 28'(VOUT_MAX_MV - VOUT_MIN_MV))
					/ 28'(VPROG_HI_CODE - VPROG_LO_CODE)); // see RULE_04
		end

	// start-up grace: overload is carried as constant current at first
	ms_t  grace_ms;
	logic oc_trip;
	always_ff @(posedge mclk or negedge arst_n)
		if (!arst_n)
		begin
			grace_ms <= '0;
			cc_hold  <= 1'b0;
		end
		else
		begin
			if (tick && grace_ms != CC_GRACE_MS)
				grace_ms <= grace_ms + 17'd1;
			cc_hold <= overload && grace_ms < CC_GRACE_MS; // see RULE_08
		end
	assign oc_trip = overload && grace_ms >= CC_GRACE_MS;

	// fault state machine and its delay timer
	sup_state_e st;
	ms_t        tmr;
	logic [1:0] ov_cnt;
	logic       arm;
	logic       restarting;
	logic       cfg_q;
	logic       cfg_rise;
	logic       success;
	assign cfg_rise = (restart_cfg_oc & restart_cfg_ot) & ~cfg_q;
	assign success  = st == st_run && restarting && vout_in_reg;
	always_ff @(posedge mclk or negedge arst_n)
		if (!arst_n)
		begin
			st         <= st_off;
			tmr        <= '0;
			arm        <= 1'b0;
			restarting <= 1'b0;
			cfg_q      <= 1'b1;
		end
		else
		begin
			cfg_q <= restart_cfg_oc & restart_cfg_ot;
			tmr   <= tick ? tmr + 17'd1 : tmr;
			case (st)
				st_off:
					if (on_s && op_on)
						st <= st_run;
				st_run:
				begin
					tmr <= '0;
					if (success)
						restarting <= 1'b0;
					if (ov_fault) // see RULE_12
						st <= (ov_cnt == OV_RETRIES) ? st_latched : st_retry;
					else if (oc_trip) // see RULE_11, RULE_14
						st <= restart_cfg_oc ? st_retry : st_latched;
					else if (ot_fault)
						st <= restart_cfg_ot ? st_retry : st_latched;
					else if (in_limit && !vout_above_40 && restart_cfg_oc)
						st <= st_hiccup; // see RULE_10
					else if (!on_s || !op_on)
						st <= st_off;
				end
				st_retry, st_hiccup:
					if (tick && tmr == RETRY_MS - 17'd1)
					begin
						st         <= st_run;
						restarting <= 1'b1;
					end
				st_latched:
				begin
					// off time is the host's duty; only the off-then-on is seen
					arm <= arm | ~on_s | ~op_on;
					if ((arm && on_s && op_on) || cfg_rise) // see RULE_15
					begin
						st         <= st_run;
						arm        <= 1'b0;
						restarting <= 1'b1;
					end
				end
				default:
					st <= st_off;
			endcase
		end

	// overvoltage count inside a one-minute window
	ms_t win_ms;
	always_ff @(posedge mclk or negedge arst_n)
		if (!arst_n)
		begin
			ov_cnt <= '0;
			win_ms <= '0;
		end
		else if (st == st_latched)
			ov_cnt <= '0;
		else if (st == st_run && ov_fault)
		begin
			if (ov_cnt == 2'd0)
				win_ms <= '0;
			if (ov_cnt != OV_RETRIES)
				ov_cnt <= ov_cnt + 2'd1;
		end
		else if (ov_cnt != 2'd0 && tick)
		begin
			if (win_ms == OV_WINDOW_MS - 17'd1)
				ov_cnt <= '0; // see RULE_13
			else
				win_ms <= win_ms + 17'd1;
		end

	// alarms set on a trip; a trip in the clearing cycle wins
	always_ff @(posedge mclk or negedge arst_n)
		if (!arst_n)
		begin
			alarm_ov   <= 1'b0;
			alarm_oc   <= 1'b0;
			alarm_ot   <= 1'b0;
			restart_ok <= 1'b0;
		end
		else
		begin
			alarm_ov <= (st == st_run && ov_fault) | (alarm_ov & ~success);
			alarm_oc <= (st == st_run && oc_trip) | (alarm_oc & ~success);
			alarm_ot <= (st == st_run && ot_fault) | (alarm_ot & ~success);
			restart_ok <= success | (restart_ok & ~(st == st_run
				&& (ov_fault | oc_trip | ot_fault))); // see RULE_17
		end

	// led and output drive follow the state
	ms_t  blink_ms;
	logic blink;
	always_ff @(posedge mclk or negedge arst_n)
		if (!arst_n)
		begin
			blink_ms   <= '0;
			blink      <= 1'b0;
			output_led <= 1'b0;
			out_enable <= 1'b0;
			latched    <= 1'b0;
		end
		else
		begin
			if (tick)
				blink_ms <= (blink_ms == BLINK_MS - 17'd1) ? '0 : blink_ms + 17'd1;
			if (tick && blink_ms == BLINK_MS - 17'd1)
				blink <= ~blink;
			output_led <= st == st_run
				&& (!(in_limit && vout_above_40) || blink); // see RULE_09
			out_enable <= st == st_run && ac_ready;
			latched    <= st == st_latched;
		end

	// mode and address straps
	always_ff @(posedge mclk or negedge arst_n)
		if (!arst_n)
		begin
			rs485_mode            <= 1'b0;
			position_address_bits <= '0;
		end
		else
		begin
			rs485_mode            <= ~pin_q2[2]; // see RULE_19
			position_address_bits <= pos_map(unit_position_pin,
				rack_position_pin); // see RULE_20
		end

	// start seen in mclk holds the link logic in reset until scl falls
	logic start_hold;
	logic link_rst_n;
	always_ff @(posedge mclk or negedge arst_n)
		if (!arst_n)
			start_hold <= 1'b0;
		else if (pin_q2[3] && pin_q3[4] && !pin_q2[4])
			start_hold <= 1'b1;
		else if (!pin_q2[3])
			start_hold <= 1'b0;
	assign link_rst_n = arst_n & ~start_hold;

	// events from the link arrive as toggles
	logic [1:0] tg_q1;
	logic [1:0] tg_q2;
	logic [1:0] tg_q3;
	logic       won_tgl;
	logic       badrd_tgl;
	always_ff @(posedge mclk or negedge arst_n)
		if (!arst_n)
		begin
			tg_q1       <= '0;
			tg_q2       <= '0;
			tg_q3       <= '0;
			alert_oe    <= 1'b0;
			alert_o     <= 1'b0;
			invalid_cmd <= 1'b0;
		end
		else
		begin
			tg_q1 <= {badrd_tgl, won_tgl};
			tg_q2 <= tg_q1;
			tg_q3 <= tg_q2;
			alert_o <= 1'b0;
			alert_oe <= alert_req | (alert_oe & ~(tg_q2[0] ^ tg_q3[0])); // see RULE_25
			invalid_cmd <= (tg_q2[1] ^ tg_q3[1]) | (invalid_cmd & ~invalid_clr); // see RULE_23
		end

	// link side: address shift, arbitration and response on scl
	logic [3:0] bitcnt;
	logic [1:0] byte_no;
	logic [7:0] shreg;
	logic [7:0] addr;
	logic       lost;
	logic [3:0] pos_q1;
	logic [3:0] pos_q2;
	logic       ap_q1;
	logic       ap_q2;
	logic       tx_on;
	logic [7:0] tx_byte;
	logic [2:0] bit_ix;
	logic       accept;
	assign tx_byte = {ADDR_BASE, pos_q2, 1'b1};
	assign bit_ix  = 3'(4'd7 - bitcnt);
	assign tx_on   = byte_no == 2'd1 && addr == ARA_BYTE && ap_q2;
	assign accept  = addr[7:1] == tx_byte[7:1] // see RULE_21
		|| (addr == ARA_BYTE && ap_q2) // see RULE_22
		|| addr == BCAST_WR;
	always_ff @(posedge scl_clk or negedge link_rst_n)
		if (!link_rst_n)
		begin
			bitcnt  <= '0;
			byte_no <= '0;
			shreg   <= '0;
			addr    <= '0;
			lost    <= 1'b0;
		end
		else
		begin
			if (bitcnt == 4'd8)
			begin
				bitcnt  <= '0;
				byte_no <= (byte_no == 2'd2) ? byte_no : byte_no + 2'd1;
			end
			else
			begin
				bitcnt <= bitcnt + 4'd1;
				shreg  <= {shreg[6:0], sda_i};
			end
			if (byte_no == 2'd0 && bitcnt == 4'd7)
				addr <= {shreg[6:0], sda_i};
			if (tx_on && bitcnt != 4'd8 && tx_byte[bit_ix] && !sda_i)
				lost <= 1'b1;
		end

	// toggles and strap copies survive link resets
	always_ff @(posedge scl_clk or negedge arst_n)
		if (!arst_n)
		begin
			won_tgl   <= 1'b0;
			badrd_tgl <= 1'b0;
			pos_q1    <= '0;
			pos_q2    <= '0;
			ap_q1     <= 1'b0;
			ap_q2     <= 1'b0;
		end
		else
		begin
			pos_q1 <= position_address_bits;
			pos_q2 <= pos_q1;
			ap_q1  <= alert_oe;
			ap_q2  <= ap_q1;
			if (byte_no == 2'd0 && bitcnt == 4'd7 && {shreg[6:0], sda_i} == BCAST_RD)
				badrd_tgl <= ~badrd_tgl;
			if (tx_on && bitcnt == 4'd7 && !lost)
				won_tgl <= ~won_tgl;
		end

	// drive on falling scl: ack, then own address during alert response
	always_ff @(negedge scl_clk or negedge link_rst_n)
		if (!link_rst_n)
		begin
			sda_oe <= 1'b0;
			sda_o  <= 1'b0;
		end
		else
		begin
			sda_o <= 1'b0;
			if (bitcnt == 4'd8)
				sda_oe <= byte_no == 2'd0 && accept;
			else
				sda_oe <= tx_on && !lost && !tx_byte[bit_ix]; // see RULE_24
		end

	a_vprog_floor: assert property (@(posedge mclk) disable iff (!arst_n) // see RULE_05
		(!serial_ctrl && !vout_cmd_valid && vprog_code < VPROG_LO_CODE)
		|=> setpoint_mv == VOUT_MIN_MV) else $error("setpoint not at minimum");
	a_vprog_ceiling: assert property (@(posedge mclk) disable iff (!arst_n) // see RULE_06
		(!serial_ctrl && !vout_cmd_valid && vprog_code > VPROG_HI_CODE)
		|=> setpoint_mv == VOUT_MAX_MV) else $error("setpoint not at maximum");
	a_serial_owns: assert property (@(posedge mclk) disable iff (!arst_n) // see RULE_07
		serial_ctrl && !vout_cmd_valid |=> serial_ctrl && $stable(setpoint_mv))
		else $error("pin moved setpoint under serial control");
	a_grace_no_oc: assert property (@(posedge mclk) disable iff (!arst_n) // see RULE_08
		grace_ms < CC_GRACE_MS - 17'd1 |-> ##1 !alarm_oc)
		else $error("overcurrent alarm during grace");
	a_ov_latch: assert property (@(posedge mclk) disable iff (!arst_n) // see RULE_12
		st == st_run && ov_fault && ov_cnt == OV_RETRIES |=> st == st_latched ##1 latched)
		else $error("fourth overvoltage did not latch");
	a_retry_delay: assert property (@(posedge mclk) disable iff (!arst_n) // see RULE_12
		$past(st) == st_retry && st == st_run |-> $past(tmr) == RETRY_MS - 17'd1)
		else $error("retry left early");
	a_led_latched: assert property (@(posedge mclk) disable iff (!arst_n) // see RULE_09
		st == st_latched [*2] |-> !output_led) else $error("led lit while latched");
	a_restart_clear: assert property (@(posedge mclk) disable iff (!arst_n) // see RULE_17
		success |=> restart_ok && !alarm_ov && !alarm_oc && !alarm_ot)
		else $error("restart did not clear alarms");
	a_alert_hold: assert property (@(posedge mclk) disable iff (!arst_n) // see RULE_25
		alert_oe && !(tg_q2[0] ^ tg_q3[0]) |=> alert_oe)
		else $error("alert released without own address");
	a_bcast_nack: assert property (@(negedge scl_clk) disable iff (!link_rst_n) // see RULE_23
		bitcnt == 4'd8 && byte_no == 2'd0 && addr == BCAST_RD |=> !sda_oe)
		else $error("broadcast read acknowledged");

endmodule : psu_supervisor

// >>> test/i2c_host_model.sv
// bus host model: clock and host side of the open-drain data line
`timescale 1ns/100ps
module i2c_host_model
(
	output logic scl_clk,
	output logic host_low,
	input  wire  sda
);
	localparam int Q = 16;

	// clock parks high between frames, data released to the pull-up
	initial
	begin
		scl_clk  = 1'b1;
		host_low = 1'b0;
	end

	// one bit: data set in the low phase, line sampled mid high phase
	task automatic bit1(input logic b, output logic s);
		host_low = ~b;
		#Q scl_clk = 1'b1;
		#Q s = sda;
		#Q scl_clk = 1'b0;
		#Q;
	endtask : bit1

	// start, address byte, ack, optional read byte with nack, stop
	task automatic xfer(input logic [7:0] a, output logic ack,
		output logic [7:0] d);
		logic s;
		d = 8'h00;
		#3 host_low = 1'b1;
		#(2 * Q) scl_clk = 1'b0;
		for (int i = 7; i >= 0; i--)
			bit1(a[i], s);
		bit1(1'b1, s);
		ack = ~s;
		// reads only when a read address is acked, so nacked broadcast reads are skipped
		if (ack && a[0])
		begin
			for (int i = 7; i >= 0; i--)
				bit1(1'b1, d[i]);
			bit1(1'b1, s);
		end
		host_low = 1'b1;
		#Q scl_clk = 1'b1;
		#Q host_low = 1'b0;
		#(2 * Q);
	endtask : xfer
endmodule : i2c_host_model

// >>> test/testbench.sv
// self-checking bench for the rectifier supervisor
`timescale 1ns/100ps
module testbench
	import psu_supervisor_pkg::*;
;
	localparam int T = 3;
	logic        mclk = 1'b0, arst_n = 1'b0;
	logic        ac_ok = 1'b1, on_pin = 1'b1, protocol_pin_open = 1'b1;
	logic        op_on = 1'b1, restart_cfg_oc = 1'b1, restart_cfg_ot = 1'b1;
	logic        overload = 1'b0, ov_fault = 1'b0, ot_fault = 1'b0;
	logic        in_limit = 1'b0, vout_above_40 = 1'b0, vout_in_reg = 1'b0;
	logic        light_load = 1'b0, alert_req = 1'b0, invalid_clr = 1'b0;
	logic        vout_cmd_valid = 1'b0;
	logic [15:0] vout_cmd_mv = 16'h0000;
	logic [11:0] vprog_code = 12'h000;
	logic [3:0]  unit_position_pin = 4'h1, rack_position_pin = 4'h1;
	logic        scl_clk, host_low, sda_o, sda_oe, alert_o, alert_oe;
	logic        serial_ctrl, out_enable, output_led, cc_hold, alarm_ov;
	logic        alarm_oc, alarm_ot, restart_ok, latched, fast_fail;
	logic        rs485_mode, invalid_cmd, ack;
	logic [15:0] setpoint_mv;
	logic [3:0]  position_address_bits;
	logic [7:0]  rb;
	wire         sda_line = ~(sda_oe | host_low);
	int          seed, i, u, r, c, fails = 0, comparisons = 0;
	int          corner [8] = '{0, 123, 124, 125, 3724, 3725, 4095, 1924};

	always #2.5 mclk = ~mclk;

	psu_supervisor #(.TICK_CYC(T)) u_psu_supervisor (
		.mclk(mclk), .arst_n(arst_n), .scl_clk(scl_clk),
		.sda_i(sda_line), .sda_o(sda_o), .sda_oe(sda_oe),
		.alert_o(alert_o), .alert_oe(alert_oe), .ac_ok(ac_ok),
		.on_pin(on_pin), .protocol_pin_open(protocol_pin_open),
		.unit_position_pin(unit_position_pin),
		.rack_position_pin(rack_position_pin), .vprog_code(vprog_code),
		.vout_cmd_valid(vout_cmd_valid), .vout_cmd_mv(vout_cmd_mv),
		.op_on(op_on), .restart_cfg_oc(restart_cfg_oc),
		.restart_cfg_ot(restart_cfg_ot), .overload(overload),
		.ov_fault(ov_fault), .ot_fault(ot_fault), .in_limit(in_limit),
		.vout_above_40(vout_above_40), .vout_in_reg(vout_in_reg),
		.light_load(light_load), .alert_req(alert_req),
		.invalid_clr(invalid_clr), .setpoint_mv(setpoint_mv),
		.serial_ctrl(serial_ctrl), .out_enable(out_enable),
		.output_led(output_led), .cc_hold(cc_hold), .alarm_ov(alarm_ov),
		.alarm_oc(alarm_oc), .alarm_ot(alarm_ot), .restart_ok(restart_ok),
		.latched(latched), .fast_fail(fast_fail), .rs485_mode(rs485_mode),
		.position_address_bits(position_address_bits),
		.invalid_cmd(invalid_cmd));

	i2c_host_model u_i2c_host_model (.scl_clk(scl_clk),
		.host_low(host_low), .sda(sda_line));

	// setpoint expected from the pin code
	function automatic logic [15:0] exp_sp(input int k);
		if (k < 124)
			return 16'h9c40;
		if (k > 3724)
			return 16'hd6d8;
		return 16'(40000 + (k - 124) * 15000 / 3600);
	endfunction : exp_sp

	// address bits from unit and rack index; blank cells give zero
	function automatic logic [3:0] exp_pos(input int n, input int m);
		if (n >= 1 && n <= 4 && m >= 1 && m <= 4)
			return 4'((m - 1) * 4 + n - 1);
		if (n >= 1 && n <= 5 && m >= 6)
			return 4'((m - 6) * 5 + n - 1);
		if (n >= 6 && n <= 7 && m >= 1)
			return 4'((m - 1) * 2 + n - 6);
		if (n >= 8 && n <= 10 && m >= 4)
			return 4'((m - 4) * 3 + n - 8);
		return 4'h0;
	endfunction : exp_pos

	task chk(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			fails++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task cyc(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask : cyc

	// bounded wait for a level, then compare it
	task automatic wait_lvl(ref logic s, input logic v, input int n);
		int k;
		k = 0;
		while (s !== v && k < n)
		begin
			cyc(1);
			k++;
		end
		chk(s, v);
	endtask : wait_lvl

	task test_done;
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : test_done

	// watchdog: the scenarios need about 33000 cycles, so allow 80000
	initial
	begin
		#(5 * 80000);
		fails++;
		test_done();
	end

	// main sequence
	initial
	begin
		seed = 44250;
		repeat (10) @(posedge mclk);
		arst_n <= 1'b1;
		cyc(4);
		chk(setpoint_mv, VOUT_MIN_MV);
		for (i = 0; i < 20; i++)
		begin
			c = (i < 8) ? corner[i] : ($random(seed) & 32'hfff);
			@(posedge mclk) vprog_code <= 12'(c);
			cyc(4);
			chk(setpoint_mv, exp_sp(c));
		end
		c = 40000 + ($unsigned($random(seed)) % 15001);
		@(posedge mclk)
		begin
			vout_cmd_valid <= 1'b1;
			vout_cmd_mv    <= 16'(c);
		end
		@(posedge mclk) vout_cmd_valid <= 1'b0;
		@(posedge mclk) vprog_code <= 12'hfff;
		cyc(4);
		chk(serial_ctrl, 1'b1);
		chk(setpoint_mv, 16'(c));
		// repower hands the setpoint back to the pin
		@(posedge mclk) arst_n <= 1'b0;
		repeat (10) @(posedge mclk);
		arst_n <= 1'b1;
		cyc(4);
		chk(setpoint_mv, 16'hd6d8);
		@(posedge mclk)
		begin
			overload          <= 1'b1;
			protocol_pin_open <= 1'b0;
		end
		cyc(4);
		chk(cc_hold, 1'b1);
		chk(alarm_oc, 1'b0);
		chk(rs485_mode, 1'b1);
		@(posedge mclk)
		begin
			overload          <= 1'b0;
			protocol_pin_open <= 1'b1;
		end
		cyc(4);
		chk(rs485_mode, 1'b0);
		// position straps, own address acked, the complemented position not
		for (i = 0; i < 8; i++)
		begin
			u = (i == 0) ? 0 : 1 + ($unsigned($random(seed)) % 10);
			r = 1 + ($unsigned($random(seed)) % 8);
			@(posedge mclk)
			begin
				unit_position_pin <= 4'(u);
				rack_position_pin <= 4'(r);
			end
			cyc(4);
			chk(position_address_bits, exp_pos(u, r));
			u_i2c_host_model.xfer({3'h4, exp_pos(u, r), 1'b0}, ack, rb);
			chk(ack, 1'b1);
			u_i2c_host_model.xfer({3'h4, ~exp_pos(u, r), 1'b0}, ack, rb);
			chk(ack, 1'b0);
		end
		u_i2c_host_model.xfer(BCAST_WR, ack, rb);
		chk(ack, 1'b1);
		u_i2c_host_model.xfer(BCAST_RD, ack, rb);
		chk(ack, 1'b0);
		cyc(2);
		chk(invalid_cmd, 1'b1);
		@(posedge mclk) invalid_clr <= 1'b1;
		@(posedge mclk) invalid_clr <= 1'b0;
		cyc(2);
		chk(invalid_cmd, 1'b0);
		// alert response: silent until an alert is pending
		u_i2c_host_model.xfer(ARA_BYTE, ack, rb);
		chk(ack, 1'b0);
		@(posedge mclk) alert_req <= 1'b1;
		@(posedge mclk) alert_req <= 1'b0;
		wait_lvl(alert_oe, 1'b1, 4);
		u_i2c_host_model.xfer(ARA_BYTE, ack, rb);
		chk(ack, 1'b1);
		chk(rb[7:1], {3'h4, exp_pos(u, r)});
		chk({sda_o, alert_o}, 2'b00);
		wait_lvl(alert_oe, 1'b0, 20);
		wait_lvl(out_enable, 1'b1, START_DELAY_MS * T + 50);
		cyc(2);
		chk(output_led, 1'b1);
		// limit above 40 v blinks, below 40 v hiccups
		@(posedge mclk)
		begin
			in_limit      <= 1'b1;
			vout_above_40 <= 1'b1;
		end
		wait_lvl(output_led, 1'b0, BLINK_MS * T + 20);
		wait_lvl(output_led, 1'b1, BLINK_MS * T + 20);
		@(posedge mclk) vout_above_40 <= 1'b0;
		wait_lvl(out_enable, 1'b0, 6);
		@(posedge mclk) in_limit <= 1'b0;
		wait_lvl(out_enable, 1'b1, RETRY_MS * T + 20);
		// overvoltage: three timed retries, the fourth trip latches
		for (i = 0; i < 4; i++)
		begin
			@(posedge mclk) ov_fault <= 1'b1;
			@(posedge mclk) ov_fault <= 1'b0;
			wait_lvl(alarm_ov, 1'b1, 3);
			wait_lvl(out_enable, 1'b0, 3);
			if (i < 3)
			begin
				cyc(RETRY_MS * T - 20);
				chk(out_enable, 1'b0);
				wait_lvl(out_enable, 1'b1, 40);
				@(posedge mclk) vout_in_reg <= 1'b1;
				cyc(3);
				chk(restart_ok, 1'b1);
				chk(alarm_ov, 1'b0);
				@(posedge mclk) vout_in_reg <= 1'b0;
			end
		end
		wait_lvl(latched, 1'b1, 4);
		cyc(2);
		chk(output_led, 1'b0);
		@(posedge mclk) on_pin <= 1'b0;
		cyc(RETRY_MS * T * 2);
		chk(latched, 1'b1);
		@(posedge mclk) on_pin <= 1'b1;
		wait_lvl(latched, 1'b0, 10);
		// overtemperature set to latch, then released by reconfiguring
		@(posedge mclk) restart_cfg_ot <= 1'b0;
		wait_lvl(out_enable, 1'b1, START_DELAY_MS * T + 50);
		@(posedge mclk) ot_fault <= 1'b1;
		@(posedge mclk) ot_fault <= 1'b0;
		wait_lvl(latched, 1'b1, 4);
		chk(alarm_ot, 1'b1);
		@(posedge mclk) restart_cfg_ot <= 1'b1;
		wait_lvl(latched, 1'b0, 6);
		wait_lvl(out_enable, 1'b1, START_DELAY_MS * T + 50);
		@(posedge mclk) ot_fault <= 1'b1;
		@(posedge mclk) ot_fault <= 1'b0;
		wait_lvl(out_enable, 1'b0, 4);
		wait_lvl(out_enable, 1'b1, RETRY_MS * T + 20);
		chk(latched, 1'b0);
		// short outage: fast return, deadline missed without regulation
		@(posedge mclk) ac_ok <= 1'b0;
		cyc(100 * T);
		@(posedge mclk) ac_ok <= 1'b1;
		wait_lvl(out_enable, 1'b1, FAST_SHORT_DL_MS * T);
		wait_lvl(fast_fail, 1'b1, FAST_SHORT_DL_MS * T + 20);
		// light load: mid outage keeps 150 ms, long outage gets 450 ms
		@(posedge mclk) light_load <= 1'b1;
		for (i = 0; i < 2; i++)
		begin
			@(posedge mclk) ac_ok <= 1'b0;
			cyc((i ? 1000 : 500) * T);
			@(posedge mclk) ac_ok <= 1'b1;
			wait_lvl(out_enable, 1'b1, 20);
			cyc(FAST_SHORT_DL_MS * T - 20);
			chk(fast_fail, 1'b0);
			c = i ? FAST_LONG_DL_MS * T : 60;
			wait_lvl(fast_fail, 1'b1, c);
		end
		test_done();
	end
endmodule : testbench
